/* File: pit_defs.svh */
// Register offsets, field positions, reset values and timing counts of the interval timer.
`ifndef PIT_DEFS_SVH
`define PIT_DEFS_SVH

`define PIT_ADDR_W          8
`define PIT_DATA_W          8
`define PIT_OFF_MODE        8'hF1
`define PIT_OFF_COUNT       8'hF2
`define PIT_OFF_PRESCALE    8'hF3
`define PIT_OFF_PORT5_DATA  8'hF5
`define PIT_OFF_PORT5_DIR   8'hF6

`define PIT_MODE_OSEL_HI    7
`define PIT_MODE_OSEL_LO    6
`define PIT_MODE_IMODE_HI   5
`define PIT_MODE_IMODE_LO   4
`define PIT_MODE_ENABLE     3
`define PIT_MODE_LOAD       2

`define PIT_PRE_MOD_HI      7
`define PIT_PRE_MOD_LO      2
`define PIT_PRE_SRC_INT     1
`define PIT_PRE_CONTINUOUS  0

`define PIT_PORT5_TIMER_OUTPUT_PIN_BIT  6
`define PIT_PORT5_TIN_BIT   2

`define PIT_RST_MODE        8'h00
`define PIT_RST_COUNT       8'h00
`define PIT_RST_PRESCALE    8'h00
`define PIT_RST_PORT5_DATA  8'h00
`define PIT_RST_PORT5_DIR   8'hFF

`define PIT_MCLK_HZ         25000000
`define PIT_ICLK_DIV        2
`define PIT_TCLK_ICLKS      4
`define PIT_TCLK_DIV        (`PIT_ICLK_DIV * `PIT_TCLK_ICLKS)

`endif

/* File: pit_pkg.sv */
// Types shared by the interval timer.
package pit_pkg;

  typedef enum logic [1:0] {
    PIT_OSEL_PORT  = 2'h0,
    PIT_OSEL_RSVD  = 2'h1,
    PIT_OSEL_TIMER_OUTPUT_PIN  = 2'h2,
    PIT_OSEL_ICLK  = 2'h3
  } pit_osel_type;

  typedef enum logic [1:0] {
    PIT_IN_EXTCLK  = 2'h0,
    PIT_IN_GATED   = 2'h1,
    PIT_IN_TRIG    = 2'h2,
    PIT_IN_RETRIG  = 2'h3
  } pit_imode_type;

  typedef enum logic [1:0] {
    PIT_TRG_WAIT   = 2'b01,
    PIT_TRG_GO     = 2'b10
  } pit_trg_type;

endpackage

/* File: pit_timer.sv */
// Prescaled 8-bit interval timer with register port, input pin modes and output pin.
`timescale 1ns/100ps
`include "pit_defs.svh"

module pit_timer
  import pit_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic [`PIT_ADDR_W-1:0] reg_addr,
  input  wire logic [`PIT_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`PIT_DATA_W-1:0] reg_rdata,
  input  wire logic                   timer_input_pin,
  output logic                        timer_output_pin,
  output logic                        timer_output_oe,
  output logic                        timer_end_irq,
  output logic                        input_edge_irq
);

  logic [7:0]        mode_ff;
  logic [7:0]        nxt_mode;
  logic [7:0]        pre_ff;
  logic [7:0]        nxt_pre;
  logic [7:0]        init_ff;
  logic [7:0]        nxt_init;
  logic [7:0]        cnt_ff;
  logic [7:0]        nxt_cnt;
  logic [5:0]        pcnt_ff;
  logic [5:0]        nxt_pcnt;
  logic [2:0]        div_ff;
  logic [2:0]        nxt_div;
  logic              halt_ff;
  logic              nxt_halt;
  logic              tog_ff;
  logic              nxt_tog;
  logic              iclk_ff;
  logic              nxt_iclk;
  logic [7:0]        pdata_ff;
  logic [7:0]        nxt_pdata;
  logic [7:0]        pdir_ff;
  logic [7:0]        nxt_pdir;
  logic              pin_ff;
  logic              nxt_pin;
  logic              oe_ff;
  logic              nxt_oe;
  logic              tend_ff;
  logic              nxt_tend;
  logic              tedge_ff;
  logic              nxt_tedge;
  logic [7:0]        rdata_ff;
  logic [7:0]        nxt_rdata;
  logic              tin_meta_ff;
  logic              tin_sync_ff;
  logic              tin_prev_ff;
  pit_trg_type       trg_ff;
  pit_trg_type       nxt_trg;

  logic              wr_mode;
  logic              wr_load;
  logic              wr_en_rise;
  logic              fall;
  logic              tick;
  logic              iclk_pulse;
  logic              enabled;
  logic              ext_src;
  logic              continuous;
  logic              ev;
  logic              pre_end;
  logic              cnt_end;
  logic              hw_load;
  logic              do_load;
  pit_imode_type     imode;
  pit_osel_type      osel;

  // Two-flop synchroniser; only the second stage and its delayed copy feed logic.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tin_meta_ff <= 1'b1;
      tin_sync_ff <= 1'b1;
      tin_prev_ff <= 1'b1;
    end else begin
      tin_meta_ff <= timer_input_pin;
      tin_sync_ff <= tin_meta_ff;
      tin_prev_ff <= tin_sync_ff;
    end
  end

  assign fall       = tin_prev_ff & ~tin_sync_ff;
  assign wr_mode    = reg_wr && (reg_addr == `PIT_OFF_MODE);
  assign wr_load    = wr_mode && reg_wdata[`PIT_MODE_LOAD];
  assign wr_en_rise = wr_mode && reg_wdata[`PIT_MODE_ENABLE] && !mode_ff[`PIT_MODE_ENABLE];
  assign tick       = (div_ff == 3'(`PIT_TCLK_DIV - 1));
  assign iclk_pulse = div_ff[0];
  assign enabled    = mode_ff[`PIT_MODE_ENABLE];
  assign ext_src    = !pre_ff[`PIT_PRE_SRC_INT];
  assign continuous = pre_ff[`PIT_PRE_CONTINUOUS];
  assign imode      = pit_imode_type'(mode_ff[`PIT_MODE_IMODE_HI:`PIT_MODE_IMODE_LO]);
  assign osel       = pit_osel_type'(mode_ff[`PIT_MODE_OSEL_HI:`PIT_MODE_OSEL_LO]);

  // Clock event for the prescaler, chosen by source and input mode.
  always_comb begin
    ev = 1'b0;
    if (enabled) begin
      if (!ext_src) begin
        ev = tick;
      end else begin
        case (imode)
          PIT_IN_EXTCLK: ev = fall;
          PIT_IN_GATED:  ev = tick && tin_sync_ff;
          PIT_IN_TRIG:   ev = tick && (trg_ff == PIT_TRG_GO);
          PIT_IN_RETRIG: ev = tick && (trg_ff == PIT_TRG_GO);
          default:       ev = 1'b0;
        endcase
      end
    end
  end

  // An edge that triggers the timer loads the initial values by itself.
  always_comb begin
    hw_load = 1'b0;
    if (enabled && ext_src && fall) begin
      case (imode)
        PIT_IN_TRIG:   hw_load = (trg_ff == PIT_TRG_WAIT);
        PIT_IN_RETRIG: hw_load = 1'b1;
        default:       hw_load = 1'b0;
      endcase
    end
  end

  assign do_load = wr_load || hw_load;
  assign pre_end = ev && (pcnt_ff == 6'h01);
  assign cnt_end = pre_end && !halt_ff && (cnt_ff == 8'h01);

  // Next state of the counting chain and the registers software writes.
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_pre   = pre_ff;
    nxt_init  = init_ff;
    nxt_cnt   = cnt_ff;
    nxt_pcnt  = pcnt_ff;
    nxt_div   = div_ff + 3'h1;
    nxt_halt  = halt_ff;
    nxt_tog   = tog_ff;
    nxt_iclk  = ~iclk_ff;
    nxt_pdata = pdata_ff;
    nxt_pdir  = pdir_ff;
    nxt_trg   = trg_ff;
    // The load bit lives for exactly one internal clock.
    if (iclk_pulse) begin
      nxt_mode[`PIT_MODE_LOAD] = 1'b0;
    end
    if (ev) begin
      if (pre_end) begin
        nxt_pcnt = pre_ff[`PIT_PRE_MOD_HI:`PIT_PRE_MOD_LO];
      end else begin
        // Modulo zero wraps 0 to 63 and so divides by sixty-four.
        nxt_pcnt = pcnt_ff - 6'h01;
      end
    end
    if (pre_end && !halt_ff) begin
      if (cnt_end) begin
        nxt_tog = ~tog_ff;
        if (continuous) begin
          nxt_cnt = init_ff;
        end else begin
          nxt_cnt  = 8'h00;
          nxt_halt = 1'b1;
          if (ext_src && (imode == PIT_IN_TRIG || imode == PIT_IN_RETRIG)) begin
            nxt_mode[`PIT_MODE_ENABLE] = 1'b0;
          end
        end
      end else begin
        // An initial value of zero wraps to 255, giving 256 counts.
        nxt_cnt = cnt_ff - 8'h01;
      end
    end
    if (!enabled) begin
      nxt_trg = PIT_TRG_WAIT;
    end else if (hw_load) begin
      nxt_trg = PIT_TRG_GO;
    end
    if (do_load) begin
      nxt_pcnt = pre_ff[`PIT_PRE_MOD_HI:`PIT_PRE_MOD_LO];
      nxt_cnt  = init_ff;
      nxt_halt = 1'b0;
    end
    if (wr_load) begin
      nxt_tog = 1'b1;
    end
    // Restarting the divider puts the first tick four internal clocks out.
    if (wr_load || wr_en_rise) begin
      nxt_div = 3'h0;
    end
    if (reg_wr) begin
      case (reg_addr)
        `PIT_OFF_MODE:       nxt_mode  = reg_wdata;
        `PIT_OFF_COUNT:      nxt_init  = reg_wdata;
        `PIT_OFF_PRESCALE:   nxt_pre   = reg_wdata;
        `PIT_OFF_PORT5_DATA: nxt_pdata = reg_wdata;
        `PIT_OFF_PORT5_DIR:  nxt_pdir  = reg_wdata;
        default:             nxt_pdir  = pdir_ff;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_ff  <= `PIT_RST_MODE;
      pre_ff   <= `PIT_RST_PRESCALE;
      init_ff  <= `PIT_RST_COUNT;
      cnt_ff   <= `PIT_RST_COUNT;
      pcnt_ff  <= 6'h00;
      div_ff   <= 3'h0;
      halt_ff  <= 1'b1;
      tog_ff   <= 1'b1;
      iclk_ff  <= 1'b0;
      pdata_ff <= `PIT_RST_PORT5_DATA;
      pdir_ff  <= `PIT_RST_PORT5_DIR;
      trg_ff   <= PIT_TRG_WAIT;
    end else begin
      mode_ff  <= nxt_mode;
      pre_ff   <= nxt_pre;
      init_ff  <= nxt_init;
      cnt_ff   <= nxt_cnt;
      pcnt_ff  <= nxt_pcnt;
      div_ff   <= nxt_div;
      halt_ff  <= nxt_halt;
      tog_ff   <= nxt_tog;
      iclk_ff  <= nxt_iclk;
      pdata_ff <= nxt_pdata;
      pdir_ff  <= nxt_pdir;
      trg_ff   <= nxt_trg;
    end
  end

  // Pin, interrupt and read-data outputs, each from its own flip-flop.
  always_comb begin
    case (osel)
      PIT_OSEL_TIMER_OUTPUT_PIN: nxt_pin = nxt_tog;
      PIT_OSEL_ICLK: nxt_pin = nxt_iclk;
      default:       nxt_pin = nxt_pdata[`PIT_PORT5_TIMER_OUTPUT_PIN_BIT];
    endcase
    if (wr_load && osel == PIT_OSEL_TIMER_OUTPUT_PIN) begin
      nxt_pin = 1'b1;
    end
    nxt_oe    = !nxt_pdir[`PIT_PORT5_TIMER_OUTPUT_PIN_BIT];
    nxt_tend  = cnt_end;
    nxt_tedge = fall;
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PIT_OFF_MODE:       nxt_rdata = mode_ff;
        `PIT_OFF_COUNT:      nxt_rdata = cnt_ff;
        `PIT_OFF_PRESCALE:   nxt_rdata = pre_ff;
        `PIT_OFF_PORT5_DATA: begin
          nxt_rdata = pdata_ff;
          nxt_rdata[`PIT_PORT5_TIN_BIT] = tin_sync_ff;
          // The pin bit always reports what the pin is driving now.
          nxt_rdata[`PIT_PORT5_TIMER_OUTPUT_PIN_BIT] = pin_ff;
        end
        `PIT_OFF_PORT5_DIR:  nxt_rdata = pdir_ff;
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      tend_ff  <= 1'b0;
      tedge_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      pin_ff   <= nxt_pin;
      oe_ff    <= nxt_oe;
      tend_ff  <= nxt_tend;
      tedge_ff <= nxt_tedge;
      rdata_ff <= nxt_rdata;
    end
  end

  assign timer_output_pin = pin_ff;
  assign timer_output_oe  = oe_ff;
  assign timer_end_irq    = tend_ff;
  assign input_edge_irq   = tedge_ff;
  assign reg_rdata        = rdata_ff;

endmodule

/* File: pit_timer_properties.sv */
// Checker of the interval timer's port timing, bound to the timer.
`timescale 1ns/100ps
module pit_timer_checker
  import pit_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer_input_pin,
  input wire logic       timer_output_pin,
  input wire logic       timer_output_oe,
  input wire logic       timer_end_irq,
  input wire logic       input_edge_irq
);
  // Output select is snooped from writes; the age of the last write keeps
  // load forcing and select changes out of the toggle checks.
  logic [1:0] osel_ff;
  logic [1:0] nxt_osel;
  logic [2:0] age_ff;
  logic [2:0] nxt_age;
  always_comb begin
    nxt_osel = osel_ff;
    nxt_age  = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
    if (reg_wr) begin
      nxt_age = 3'h0;
    end
    if (reg_wr && reg_addr == 8'hF1) begin
      nxt_osel = reg_wdata[7:6];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      osel_ff <= 2'h0;
      age_ff  <= 3'h0;
    end else begin
      osel_ff <= nxt_osel;
      age_ff  <= nxt_age;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  end_pulse_a: assert property (timer_end_irq |=> !timer_end_irq)
    else $error("end request longer than one cycle");
  edge_pulse_a: assert property (input_edge_irq |=> !input_edge_irq)
    else $error("edge request longer than one cycle");
  fall_irq_a: assert property ($fell(timer_input_pin) |-> ##[3:5] input_edge_irq)
    else $error("input fall without edge request");
  toggle_end_a: assert property (timer_end_irq && osel_ff == 2'h2 && age_ff > 3'h3
    |-> timer_output_pin != $past(timer_output_pin, 2))
    else $error("output did not toggle at end of count");
  clk_out_a: assert property (osel_ff == 2'h3 && age_ff > 3'h3
    |-> timer_output_pin != $past(timer_output_pin))
    else $error("clock output not toggling");
  load_high_a: assert property (reg_wr && reg_addr == 8'hF1 && reg_wdata[7:6] == 2'h2
    && reg_wdata[2] |-> ##[1:2] timer_output_pin)
    else $error("output not forced high on load");
  oe_change_a: assert property ($changed(timer_output_oe) |-> age_ff < 3'h2)
    else $error("output enable moved without a write");
endmodule

bind pit_timer pit_timer_checker pit_timer_checker_i (
  .mclk            (mclk),
  .srst            (srst),
  .reg_addr        (reg_addr),
  .reg_wdata       (reg_wdata),
  .reg_wr          (reg_wr),
  .reg_rd          (reg_rd),
  .reg_rdata       (reg_rdata),
  .timer_input_pin (timer_input_pin),
  .timer_output_pin(timer_output_pin),
  .timer_output_oe (timer_output_oe),
  .timer_end_irq   (timer_end_irq),
  .input_edge_irq  (input_edge_irq)
);

/* File: pit_pin_model.sv */
// Model of the signal source wired to the timer input pin.
`timescale 1ns/100ps
module pit_pin_model (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic run,
  output logic      pin
);
  // The line has a pull-up, so it idles high; a half period of six clocks
  // leaves the synchroniser room to see every fall.
  logic [2:0] cnt_ff;
  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      cnt_ff <= 3'h0;
      pin    <= 1'h1;
    end else if (cnt_ff == 3'h5) begin
      cnt_ff <= 3'h0;
      pin    <= !pin;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule

/* File: prescaled_interval_timer_test.sv */
// Self-checking bench of the prescaled interval timer.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module prescaled_interval_timer_test
  import pit_pkg::*;
;
  logic       mclk;
  logic       srst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       pin_in;
  logic       pin_run;
  logic       timer_output_pin;
  logic       timer_output_oe;
  logic       timer_end_irq;
  logic       input_edge_irq;
  int         n_errors;
  int         samples_checked;

  pit_timer pit_timer_i (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_input_pin(pin_in), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe), .timer_end_irq(timer_end_irq),
    .input_edge_irq(input_edge_irq)
  );
  pit_pin_model pit_pin_model_i (.mclk(mclk), .srst(srst), .run(pin_run), .pin(pin_in));

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask

  // Counts clocks up to the next end request; the bound cuts a hang short.
  task automatic wait_end(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (timer_end_irq !== 1'h1 && n < 3000);
    @(posedge mclk);
  endtask

  task automatic cnt_irq(input int cyc, inout int ne, inout int nf);
    repeat (cyc) begin
      @(negedge mclk);
      ne += (timer_end_irq === 1'h1);
      nf += (input_edge_irq === 1'h1);
    end
    @(posedge mclk);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    logic       p;
    rd(8'hF1, d);
    `CHK(d, 8'h00)
    wr(8'hF6, 8'hBF);
    wr(8'hA0, 8'h5A);
    rd(8'hA0, d);
    `CHK(d, 8'h00)
    `CHK(timer_output_oe, 1'h1)
    wr(8'hF3, 8'h07);
    rd(8'hF3, d);
    `CHK(d, 8'h07)
    wr(8'hF1, 8'hC0);
    @(negedge mclk);
    p = timer_output_pin;
    @(negedge mclk);
    `CHK(timer_output_pin, ~p)
    repeat (12) @(posedge mclk);
  endtask

  task automatic t_period(input logic [7:0] pre, input logic [7:0] cnt, input int exp);
    int n;
    wr(8'hF3, pre);
    wr(8'hF2, cnt);
    wr(8'hF1, 8'h8C);
    wait_end(n);
    wait_end(n);
    `CHK(n, exp)
  endtask

  task automatic t_reload;
    int n;
    wr(8'hF2, 8'h01);
    wait_end(n);
    `CHK(n > 16, 1'h1)
    wait_end(n);
    `CHK(n, 16)
  endtask

  task automatic t_single;
    int n;
    int ne;
    int nf;
    logic [7:0] d;
    ne = 0;
    nf = 0;
    wr(8'hF1, 8'h80);
    wr(8'hF3, 8'h06);
    wr(8'hF2, 8'h04);
    wr(8'hF1, 8'h8C);
    `CHK(timer_output_pin, 1'h1)
    wait_end(n);
    `CHK(n inside {[31:34]}, 1'h1)
    cnt_irq(100, ne, nf);
    `CHK(ne, 0)
    rd(8'hF2, d);
    `CHK(d, 8'h00)
    rd(8'hF1, d);
    `CHK(d, 8'h88)
    `CHK(timer_output_pin, 1'h0)
    wr(8'hF5, 8'h40);
    `CHK(timer_output_pin, 1'h0)
    rd(8'hF5, d);
    `CHK(d[6], 1'h0)
    wr(8'hF1, 8'h08);
    repeat (2) @(posedge mclk);
    `CHK(timer_output_pin, 1'h1)
  endtask

  task automatic t_freeze;
    logic [7:0] d1;
    logic [7:0] d2;
    wr(8'hF2, 8'hC8);
    wr(8'hF1, 8'h8C);
    repeat (40) @(posedge mclk);
    wr(8'hF1, 8'h80);
    rd(8'hF2, d1);
    repeat (50) @(posedge mclk);
    rd(8'hF2, d2);
    `CHK(d2, d1)
    `CHK(d1 < 8'hC8, 1'h1)
    wr(8'hF1, 8'h88);
    repeat (30) @(posedge mclk);
    rd(8'hF2, d2);
    `CHK(d2 < d1, 1'h1)
  endtask

  task automatic t_ext;
    int ne;
    int nf;
    ne = 0;
    nf = 0;
    wr(8'hF3, 8'h05);
    wr(8'hF2, 8'h02);
    wr(8'hF1, 8'h8C);
    pin_run <= 1'h1;
    cnt_irq(72, ne, nf);
    pin_run <= 1'h0;
    cnt_irq(12, ne, nf);
    `CHK(nf, 6)
    `CHK(ne, 3)
  endtask

  // The idle pin is high, so the gate stays open and the internal clock counts.
  task automatic t_gated;
    int n;
    wr(8'hF3, 8'h05);
    wr(8'hF2, 8'h02);
    wr(8'hF1, 8'h9C);
    wait_end(n);
    wait_end(n);
    `CHK(n, 16)
  endtask

  // Only the first fall loads and starts; the single-pass end then drops enable.
  task automatic t_trig;
    int ne;
    int nf;
    logic [7:0] d;
    ne = 0;
    nf = 0;
    wr(8'hF3, 8'h04);
    wr(8'hF1, 8'hA8);
    cnt_irq(20, ne, nf);
    `CHK(ne, 0)
    pin_run <= 1'h1;
    cnt_irq(60, ne, nf);
    pin_run <= 1'h0;
    `CHK(ne, 1)
    `CHK(nf, 5)
    rd(8'hF1, d);
    `CHK(d, 8'hA0)
  endtask

  // Falls closer together than the count interval keep the timer from ending.
  task automatic t_retrig;
    int n;
    int ne;
    int nf;
    ne = 0;
    nf = 0;
    wr(8'hF3, 8'h05);
    wr(8'hF2, 8'h03);
    wr(8'hF1, 8'hB8);
    pin_run <= 1'h1;
    cnt_irq(72, ne, nf);
    pin_run <= 1'h0;
    `CHK(ne, 0)
    `CHK(nf, 6)
    wait_end(n);
    `CHK(n inside {[14:21]}, 1'h1)
    wait_end(n);
    `CHK(n, 24)
  endtask

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // The whole run needs under 10000 clocks; the limit leaves ample margin.
  initial begin
    #1600000;
    n_errors++;
    finish_test;
  end

  initial begin
    n_errors        = 0;
    samples_checked = 0;
    srst            = 1'h1;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'h0;
    reg_rd          = 1'h0;
    pin_run         = 1'h0;
    repeat (3) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    t_regs;
    t_period(8'h07, 8'h01, 8);
    t_period(8'h03, 8'h01, 512);
    t_period(8'h07, 8'h00, 2048);
    t_period(8'h0B, 8'h03, 48);
    t_reload;
    t_single;
    t_freeze;
    t_ext;
    t_gated;
    t_trig;
    t_retrig;
    finish_test;
  end
endmodule
